// [rtl/stop_ctl_pkg.sv]
// package for the standby and subclock controller
// assumes a single 10 MHz ref_clk; shared by all design files
package stop_ctl_pkg;
   // clock rate in kHz
   localparam int unsigned CLK_KHZ = 10_000;
   // standby select encodings (hi,lo)
   localparam logic [1:0] SEL_IDLE1 = 2'b00;
   localparam logic [1:0] SEL_STOP_A = 2'b01;
   localparam logic [1:0] SEL_IDLE2 = 2'b10;
   localparam logic [1:0] SEL_STOP_B = 2'b11;
   // stabilize select width and reset value (selects 2^16 periods)
   localparam int unsigned STAB_SEL_W = 3;
   localparam logic [2:0] STAB_SEL_RESET = 3'h4;
   // stabilization exponent base: setting n waits 2^(n+12) periods
   localparam int unsigned STAB_BASE_EXP = 12;
   localparam int unsigned STAB_W = 20;
   // noise filter sampling settings from fxx/64 upward block the third pin
   localparam logic [2:0] FILTER_SLOW_MIN = 3'h3;
   // clock switch settle count in cycles
   localparam logic [3:0] SWITCH_CYCLES = 4'h4;
   // number of maskable external pins
   localparam int unsigned EXT_N = 11;
   localparam int unsigned EXT_THREE_IDX = 3;
   // power state
   typedef enum logic [2:0] {
      ST_NORMAL, ST_IDLE2, ST_STOP, ST_STABILIZE
   } power_state_e;
   // cycle count for a stabilize setting
   function automatic logic [STAB_W-1:0] stab_len(input logic [2:0] sel);
      logic [4:0] e;
      e = 5'(sel) + 5'(STAB_BASE_EXP);
      if (e > 5'd19) begin
         e = 5'd19;
      end
      stab_len = STAB_W'(1) << e;
   endfunction
endpackage

// [rtl/stab_counter.sv]
// dedicated oscillator stabilization counter
// assumes start is a one-cycle pulse on ref_clk
`timescale 1ns/1ps
module stab_counter
   import stop_ctl_pkg::*;
(
   input wire logic ref_clk, // system clock
   input wire logic reset, // sync reset, high
   input wire logic start, // begin counting
   input wire logic [STAB_W-1:0] length, // cycles to count
   output logic overflow, // one-cycle done pulse
   output logic busy // counting
);
   logic [STAB_W-1:0] count_reg; // remaining cycles

   // count down; overflow on reaching one
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         count_reg <= '0;
         busy <= 1'b0;
         overflow <= 1'b0;
      end else if (start) begin
         count_reg <= length;
         busy <= 1'b1;
         overflow <= 1'b0;
      end else if (busy) begin
         count_reg <= count_reg - STAB_W'(1);
         overflow <= (count_reg == STAB_W'(1));
         busy <= (count_reg != STAB_W'(1));
      end else begin
         overflow <= 1'b0;
      end
   end
endmodule

// [rtl/standby_ctl.sv]
// standby, stop and subclock mode controller
// assumes cpu software drives control bits as levels, wake inputs synchronous
`timescale 1ns/1ps
module standby_ctl
   import stop_ctl_pkg::*;
(
   input wire logic ref_clk, // 10 MHz clock
   input wire logic reset, // sync reset from any source
   input wire logic standby_select_hi, // standby select upper bit
   input wire logic standby_select_lo, // standby select lower bit
   input wire logic standby_trigger, // one-cycle trigger write
   input wire logic nonmask0_wake_mask, // mask nonmaskable pin wake
   input wire logic nonmask1_wake_mask, // mask watchdog interval wake
   input wire logic maskable_wake_mask, // mask all maskable wakes
   input wire logic nmi_pin, // nonmaskable pin request
   input wire logic watchdog_interval_irq, // watchdog interval request
   input wire logic [EXT_N-1:0] ext_irq, // external pins first..last
   input wire logic [EXT_N-1:0] ext_irq_enable, // per pin unmask
   input wire logic periph_irq, // unmasked request from stop-capable unit
   input wire logic [2:0] noise_filter_control, // third pin filter select
   input wire logic req_higher_prio, // request outranks current handler
   input wire logic in_handler, // stop entered inside a handler
   input wire logic irq_enabled, // cpu interrupt enable state
   input wire logic [STAB_SEL_W-1:0] osc_stabilize_select, // stabilize setting
   input wire logic osc_select_write, // load the stabilize setting
   input wire logic subclock_select, // request subclock system clock
   input wire logic main_osc_stop, // halt main oscillator request
   input wire logic adc_busy, // converter running
   output logic main_osc_en, // main oscillator running
   output logic cpu_clk_en, // cpu clock gate
   output logic periph_clk_en, // main-clock peripherals and pll gate
   output logic sub_osc_en, // subclock oscillator running
   output logic sysclk_is_sub, // system clock mux select
   output logic clock_switch_status, // switch to subclock complete
   output logic wake_ack, // one-cycle acknowledge pulse
   output logic wake_branch, // one-cycle branch-to-handler pulse
   output logic wake_continue, // one-cycle next-instruction pulse
   output logic adc_halt, // converter halted by stop
   output logic adc_result_invalid, // conversion results invalid
   output logic [STAB_SEL_W-1:0] stab_sel_value // current stabilize setting
);
   power_state_e state_reg, state_next; // power state
   logic [STAB_SEL_W-1:0] stab_sel_reg; // stabilize setting
   logic nmi_kind_reg; // wake source was nonmaskable
   logic hi_kind_reg; // wake outranked handler
   logic wake_any; // unmasked wake request present
   logic wake_nm; // nonmaskable part
   logic [EXT_N-1:0] ext_ok; // unmasked external pins
   logic stop_req; // stop entry request
   logic stab_start; // begin stabilization
   logic stab_done; // counter overflow
   logic stab_busy; // counter running
   logic [3:0] sw_cnt_reg; // clock switch settle
   logic adc_was_reg; // converter halted by stop
   logic boot_reg; // reset stabilization pending
   logic reset_wait_reg; // current stabilization follows a reset

   // nonmaskable sources with their own masks
   assign wake_nm = (nmi_pin & ~nonmask0_wake_mask) |
      (watchdog_interval_irq & ~nonmask1_wake_mask);

   // external pins, third pin blocked by slow filtering
   always_comb begin
      ext_ok = ext_irq & ext_irq_enable;
      if (noise_filter_control >= FILTER_SLOW_MIN) begin
         ext_ok[EXT_THREE_IDX] = 1'b0;
      end
   end

   // any wake, maskable gated by the global mask
   assign wake_any = wake_nm |
      (~maskable_wake_mask & ((|ext_ok) | periph_irq));

   // stop encodings 01 and 11
   assign stop_req = standby_trigger & standby_select_lo;

   // next power state
   always_comb begin
      state_next = state_reg;
      stab_start = 1'b0;
      case (state_reg)
         ST_NORMAL: begin
            if (standby_trigger && !sysclk_is_sub && !wake_any) begin
               if (stop_req) begin
                  state_next = ST_STOP;
               end else if ({standby_select_hi, standby_select_lo} == SEL_IDLE2) begin
                  state_next = ST_IDLE2;
               end
            end
         end
         ST_IDLE2: begin
            if (wake_any) begin
               state_next = ST_STABILIZE;
               stab_start = 1'b1;
            end
         end
         ST_STOP: begin
            if (wake_any) begin
               state_next = ST_STABILIZE;
               stab_start = 1'b1;
            end
         end
         ST_STABILIZE: begin
            if (stab_done) begin
               state_next = ST_NORMAL;
            end
         end
         default: state_next = ST_NORMAL;
      endcase
   end

   // state register; pending request at entry keeps normal, stop is not entered
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_reg <= ST_STABILIZE;
      end else begin
         state_reg <= state_next;
      end
   end

   // reset stabilization launch
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         boot_reg <= 1'b1;
      end else begin
         boot_reg <= 1'b0;
      end
   end

   // a reset exit is an ordinary reset: no release pulses after its wait
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         reset_wait_reg <= 1'h1;
      end else if (stab_start) begin
         reset_wait_reg <= 1'h0; // interrupt wake from here on
      end
   end

   // stabilize setting, reset to the 2^16 value
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         stab_sel_reg <= STAB_SEL_RESET;
      end else if (osc_select_write && state_reg == ST_NORMAL) begin
         stab_sel_reg <= osc_stabilize_select;
      end
   end
   assign stab_sel_value = stab_sel_reg;

   // dedicated stabilization counter
   stab_counter i_stab_counter (
      .ref_clk(ref_clk),
      .reset(reset),
      .start(stab_start | boot_reg),
      .length(stab_len(stab_sel_reg)),
      .overflow(stab_done),
      .busy(stab_busy)
   );

   // remember wake kind for the release action
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         nmi_kind_reg <= 1'b0;
         hi_kind_reg <= 1'b0;
      end else if (stab_start) begin
         nmi_kind_reg <= wake_nm;
         hi_kind_reg <= wake_nm | ~in_handler | req_higher_prio;
      end
   end

   // release action pulses after overflow of an interrupt wake
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wake_ack <= 1'b0;
         wake_branch <= 1'b0;
         wake_continue <= 1'b0;
      end else if (state_reg == ST_STABILIZE && stab_done && !boot_reg && stab_busy == 1'b0
                   && !reset_wait_reg && (nmi_kind_reg | hi_kind_reg)) begin
         wake_ack <= 1'b1;
         wake_branch <= nmi_kind_reg | irq_enabled;
         wake_continue <= ~nmi_kind_reg & ~irq_enabled;
      end else if (state_reg == ST_STABILIZE && stab_done && !reset_wait_reg) begin
         wake_ack <= 1'b0;
         wake_branch <= 1'b0;
         wake_continue <= 1'b1;
      end else begin
         wake_ack <= 1'b0;
         wake_branch <= 1'b0;
         wake_continue <= 1'b0;
      end
   end

   // clock switch settle and status
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sysclk_is_sub <= 1'b0;
         sw_cnt_reg <= '0;
         clock_switch_status <= 1'b0;
      end else if (state_reg == ST_NORMAL && subclock_select != sysclk_is_sub) begin
         if (sw_cnt_reg == SWITCH_CYCLES) begin
            sysclk_is_sub <= subclock_select;
            clock_switch_status <= subclock_select;
            sw_cnt_reg <= '0;
         end else begin
            sw_cnt_reg <= sw_cnt_reg + 4'h1;
         end
      end else begin
         sw_cnt_reg <= '0;
      end
   end

   // oscillator and clock gates; subclock always runs
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         main_osc_en <= 1'b1;
         cpu_clk_en <= 1'b0;
         periph_clk_en <= 1'b0;
         sub_osc_en <= 1'b1;
      end else begin
         main_osc_en <= (state_next != ST_STOP) &&
            !(sysclk_is_sub && main_osc_stop);
         cpu_clk_en <= (state_next == ST_NORMAL);
         periph_clk_en <= (state_next == ST_NORMAL) &&
            !(sysclk_is_sub && main_osc_stop);
         sub_osc_en <= 1'b1;
      end
   end

   // converter halt and invalid marking across stop
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         adc_was_reg <= 1'b0;
         adc_halt <= 1'b0;
         adc_result_invalid <= 1'b0;
      end else if (state_next == ST_STOP && state_reg == ST_NORMAL && adc_busy) begin
         adc_was_reg <= 1'b1;
         adc_halt <= 1'b1;
         adc_result_invalid <= 1'b1;
      end else if (state_reg == ST_NORMAL && adc_was_reg) begin
         adc_was_reg <= 1'b0;
         adc_halt <= 1'b0;
      end else if (state_reg == ST_NORMAL && !adc_busy) begin
         adc_result_invalid <= 1'b0;
      end
   end

   // assertions
   property p_stop_entry;
      @(posedge ref_clk) disable iff (reset)
         (state_reg == ST_NORMAL && stop_req && !wake_any && !sysclk_is_sub)
         |=> state_reg == ST_STOP;
   endproperty
   a_stop_entry: assert property (p_stop_entry) else $error("stop not entered");

   property p_osc_off;
      @(posedge ref_clk) disable iff (reset)
         (state_reg == ST_STOP) |-> (!main_osc_en && !cpu_clk_en && sub_osc_en);
   endproperty
   a_osc_off: assert property (p_osc_off) else $error("stop clocks wrong");

   property p_pending;
      @(posedge ref_clk) disable iff (reset)
         (state_reg == ST_NORMAL && stop_req && wake_any) |=> state_reg != ST_STOP;
   endproperty
   a_pending: assert property (p_pending) else $error("pending request ignored");

   property p_wake;
      @(posedge ref_clk) disable iff (reset)
         (state_reg == ST_STOP && wake_any) |=> state_reg == ST_STABILIZE;
   endproperty
   a_wake: assert property (p_wake) else $error("wake missed");

   property p_masked;
      @(posedge ref_clk) disable iff (reset)
         (state_reg == ST_STOP && !wake_nm && maskable_wake_mask) |=> state_reg == ST_STOP;
   endproperty
   a_masked: assert property (p_masked) else $error("masked wake");

   property p_stab;
      @(posedge ref_clk) disable iff (reset)
         (state_reg == ST_STABILIZE && !stab_done) |=> state_reg == ST_STABILIZE;
   endproperty
   a_stab: assert property (p_stab) else $error("left before overflow");

   property p_low_prio;
      @(posedge ref_clk) disable iff (reset)
         $rose(wake_continue) && !nmi_kind_reg && !hi_kind_reg |-> !wake_ack;
   endproperty
   a_low_prio: assert property (p_low_prio) else $error("low request acked");

   property p_reset_setting;
      @(posedge ref_clk) $fell(reset) |-> stab_sel_reg == STAB_SEL_RESET;
   endproperty
   a_reset_setting: assert property (p_reset_setting) else $error("bad reset setting");

   // the wait after a reset ends without any wake pulse
   property p_reset_quiet;
      @(posedge ref_clk) disable iff (reset)
         reset_wait_reg |=> (!wake_ack && !wake_branch && !wake_continue);
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("pulse after reset");
endmodule

// [sim/clock_soft_model.sv]
// software model that drives the clock-control bits of the standby controller
// assumes cmd is driven by non-blocking assignment on the falling edge
`timescale 1ns/1ps
module clock_soft_model #(
   parameter int RESTART_WAIT = 64
) (
   input wire logic ref_clk, // system clock
   input wire logic [1:0] cmd, // 1 to subclock, 2 stop main, 3 back to main
   output logic subclock_select, // subclock request bit
   output logic main_osc_stop, // main oscillator halt bit
   output logic pll_enable, // pll enable bit
   output logic [2:0] clock_divider_sel // divider bits
);
   initial begin
      subclock_select = 1'h0;
      main_osc_stop = 1'h0;
      pll_enable = 1'h1;
      clock_divider_sel = 3'h0; // fastest setting, far above four subclocks
   end
   // one software action per command
   always @(negedge ref_clk) begin
      case (cmd)
         2'h1: subclock_select <= 1'h1; // divider bits left untouched
         2'h2: begin
            pll_enable <= 1'h0; // pll off before the oscillator
            @(negedge ref_clk);
            main_osc_stop <= 1'h1;
         end
         2'h3: begin
            main_osc_stop <= 1'h0; // restart and let it settle first
            repeat (RESTART_WAIT) @(negedge ref_clk);
            subclock_select <= 1'h0;
         end
         default: ;
      endcase
   end
endmodule

// [sim/test_standby_ctl.sv]
// testbench for the standby and subclock controller
// assumes a 10 MHz clock and inputs driven on the falling edge
`timescale 1ns/1ps
module test_standby_ctl;
   import stop_ctl_pkg::*;
   logic ref_clk = 1'h0, reset = 1'h1, standby_select_hi = 1'h0, standby_select_lo = 1'h0;
   logic standby_trigger = 1'h0, nonmask0_wake_mask = 1'h0, nonmask1_wake_mask = 1'h0;
   logic maskable_wake_mask = 1'h0, nmi_pin = 1'h0, watchdog_interval_irq = 1'h0;
   logic periph_irq = 1'h0, req_higher_prio = 1'h0, in_handler = 1'h0, irq_enabled = 1'h0;
   logic osc_select_write = 1'h0, adc_busy = 1'h0, subclock_select, main_osc_stop;
   logic [EXT_N-1:0] ext_irq = '0, ext_irq_enable = '1;
   logic [2:0] noise_filter_control = 3'h0, osc_stabilize_select = 3'h0;
   logic [1:0] cmd = 2'h0;
   logic main_osc_en, cpu_clk_en, periph_clk_en, sub_osc_en, sysclk_is_sub;
   logic clock_switch_status, wake_ack, wake_branch, wake_continue, adc_halt;
   logic adc_result_invalid;
   logic [2:0] stab_sel_value;
   logic [3:0] exp_q[$]; // {ack matters, ack, branch, continue}
   logic [3:0] e;
   logic [3:0] exps[4] = '{4'hE, 4'hE, 4'h1, 4'h9};
   logic [1:0] sels[4] = '{SEL_STOP_A, SEL_STOP_B, SEL_IDLE2, SEL_STOP_A};
   int error_cnt = 0, n_tests = 0, seed, cnt, idx;
   always #50 ref_clk = ~ref_clk;
   standby_ctl i_standby_ctl (.ref_clk(ref_clk), .reset(reset),
      .standby_select_hi(standby_select_hi), .standby_select_lo(standby_select_lo),
      .standby_trigger(standby_trigger), .nonmask0_wake_mask(nonmask0_wake_mask),
      .nonmask1_wake_mask(nonmask1_wake_mask), .maskable_wake_mask(maskable_wake_mask),
      .nmi_pin(nmi_pin), .watchdog_interval_irq(watchdog_interval_irq), .ext_irq(ext_irq),
      .ext_irq_enable(ext_irq_enable), .periph_irq(periph_irq),
      .noise_filter_control(noise_filter_control), .req_higher_prio(req_higher_prio),
      .in_handler(in_handler), .irq_enabled(irq_enabled),
      .osc_stabilize_select(osc_stabilize_select), .osc_select_write(osc_select_write),
      .subclock_select(subclock_select), .main_osc_stop(main_osc_stop), .adc_busy(adc_busy),
      .main_osc_en(main_osc_en), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
      .sub_osc_en(sub_osc_en), .sysclk_is_sub(sysclk_is_sub),
      .clock_switch_status(clock_switch_status), .wake_ack(wake_ack),
      .wake_branch(wake_branch), .wake_continue(wake_continue), .adc_halt(adc_halt),
      .adc_result_invalid(adc_result_invalid), .stab_sel_value(stab_sel_value));
   clock_soft_model i_clock_soft_model (.ref_clk(ref_clk), .cmd(cmd),
      .subclock_select(subclock_select), .main_osc_stop(main_osc_stop),
      .pll_enable(), .clock_divider_sel());
   // compare one value, count and report
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // verdict and end of run
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // bounded wait for the cpu clock gate to reach a level
   task automatic wait_cpu(input int bound);
      cnt = 0;
      while (cpu_clk_en !== 1'h1) begin
         tick(1);
         cnt++;
         if (cnt > bound) begin
            error_cnt++;
            close_out();
         end
      end
   endtask
   // trigger a standby entry and check the gates
   task automatic enter(input logic [1:0] sel);
      {standby_select_hi, standby_select_lo} <= sel;
      tick(1);
      standby_trigger <= 1'h1;
      tick(1);
      standby_trigger <= 1'h0;
      tick(3);
      check(16'(cpu_clk_en), 16'h0);
      check(16'(periph_clk_en), 16'h0);
      check(16'(main_osc_en), 16'(sel == SEL_IDLE2));
      check(16'(sub_osc_en), 16'h1);
   endtask
   // wake pulse watcher takes the oldest expectation
   always @(negedge ref_clk) begin
      if (wake_branch === 1'h1 || wake_continue === 1'h1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 4'h3;
         check(16'({wake_branch, wake_continue}), 16'(e[1:0]));
         if (e[3]) check(16'(wake_ack), 16'(e[2]));
      end
   end
   initial begin
      seed = 37;
      tick(2);
      check(16'({cpu_clk_en, main_osc_en, stab_sel_value}), 16'h0C);
      tick(14);
      reset <= 1'h0;
      wait_cpu(70000);
      check(16'(cnt >= 65534), 16'h1);
      $display("reset wait done");
      osc_select_write <= 1'h1;
      tick(1);
      osc_select_write <= 1'h0;
      tick(2);
      check(16'(stab_sel_value), 16'h0);
      periph_irq <= 1'h1;
      {standby_select_hi, standby_select_lo} <= SEL_STOP_A;
      standby_trigger <= 1'h1;
      tick(1);
      standby_trigger <= 1'h0;
      tick(3);
      check(16'({cpu_clk_en, main_osc_en}), 16'h3);
      periph_irq <= 1'h0;
      cmd <= 2'h1;
      tick(1);
      cmd <= 2'h0;
      for (int i = 0; i < 20 && clock_switch_status !== 1'h1; i++) tick(1);
      check(16'({clock_switch_status, sysclk_is_sub}), 16'h3);
      cmd <= 2'h2;
      tick(1);
      cmd <= 2'h0;
      tick(8);
      check(16'(main_osc_en), 16'h0);
      cmd <= 2'h3;
      tick(1);
      cmd <= 2'h0;
      tick(90);
      check(16'({main_osc_en, clock_switch_status, sysclk_is_sub}), 16'h4);
      $display("subclock test done");
      for (int k = 0; k < 4; k++) begin
         {in_handler, req_higher_prio} <= (k == 1) ? 2'h3 : (k == 3) ? 2'h2 : 2'h0;
         irq_enabled <= (k < 2) ? 1'($random(seed)) : 1'h0;
         adc_busy <= 1'h1;
         enter(sels[k]);
         if (k != 2) check(16'(adc_halt), 16'h1);
         {nonmask0_wake_mask, nonmask1_wake_mask, maskable_wake_mask} <= 3'h7;
         {nmi_pin, watchdog_interval_irq, periph_irq} <= 3'h7;
         ext_irq <= '1;
         tick(10);
         check(16'(cpu_clk_en), 16'h0);
         {nonmask0_wake_mask, nonmask1_wake_mask, maskable_wake_mask} <= 3'h0;
         {nmi_pin, watchdog_interval_irq, periph_irq} <= 3'h0;
         ext_irq <= 11'h008;
         noise_filter_control <= 3'(3 + ($unsigned($random(seed)) % 5));
         tick(10);
         check(16'(cpu_clk_en), 16'h0);
         ext_irq <= '0;
         idx = $unsigned($random(seed)) % 10;
         if (idx >= 3) idx++;
         exp_q.push_back(exps[k]);
         case (k)
            0: nmi_pin <= 1'h1;
            1: watchdog_interval_irq <= 1'h1;
            2: ext_irq[idx] <= 1'h1;
            default: periph_irq <= 1'h1;
         endcase
         wait_cpu(6000);
         check(16'(cnt >= 4094), 16'h1);
         if (k != 2) check(16'(adc_result_invalid), 16'h1);
         {nmi_pin, watchdog_interval_irq, periph_irq} <= 3'h0;
         ext_irq <= '0;
         adc_busy <= 1'h0;
         tick(4);
         check(16'({adc_halt, adc_result_invalid}), 16'h0);
         $display("wake test %0d done", k);
      end
      enter(SEL_STOP_B);
      reset <= 1'h1;
      tick(16);
      check(16'(stab_sel_value), 16'h4);
      reset <= 1'h0;
      tick(4300);
      check(16'(cpu_clk_en), 16'h0);
      check(16'(exp_q.size()), 16'h0);
      $display("reset exit test done");
      close_out();
   end
endmodule
